// >>> hdl/cks_pkg.sv
// clock source selector package: configuration encodings, field layouts and reset values
// assumes every consumer imports the whole package; the fuse fields are static after power-up

package cks_pkg;

  // ****************************************************************
  // primary oscillator mode field of the clock configuration word
  // ****************************************************************
  typedef enum logic [3:0] {
    CKS_MODE_LOW_POWER_CRYSTAL     = 4'h0,
    CKS_MODE_RESONATOR             = 4'h1,
    CKS_MODE_HIGH_SPEED_CRYSTAL    = 4'h2,
    CKS_MODE_EXTERNAL_RC           = 4'h3,
    CKS_MODE_EXTERNAL_RC_INSTRUCTION_CLOCK_OUTPUT    = 4'h4,
    CKS_MODE_INTERNAL              = 4'h5,
    CKS_MODE_INTERNAL_INSTRUCTION_CLOCK_OUTPUT       = 4'h6,
    CKS_MODE_EXT_CLOCK_LOW_POWER   = 4'h7,
    CKS_MODE_EXT_CLOCK_LOW_INSTRUCTION_CLOCK_OUTPUT  = 4'h8,
    CKS_MODE_EXT_CLOCK_MEDIUM_POWER = 4'h9,
    CKS_MODE_EXT_CLOCK_MEDIUM_INSTRUCTION_CLOCK_OUTPUT = 4'hA,
    CKS_MODE_EXT_CLOCK_HIGH_POWER  = 4'hB,
    CKS_MODE_EXT_CLOCK_HIGH_INSTRUCTION_CLOCK_OUTPUT = 4'hC
  } cks_osc_mode_t;

  // ****************************************************************
  // clock source select field
  // ****************************************************************
  localparam logic [1:0] CKS_SRC_PRIMARY   = 2'h0;
  localparam logic [1:0] CKS_SRC_SECONDARY = 2'h1;
  localparam int         CKS_SRC_INT_BIT   = 1;

  // effective clock path after all muxing
  typedef enum logic [2:0] {
    CKS_PATH_PRIMARY  = 3'h0,
    CKS_PATH_PLL      = 3'h1,
    CKS_PATH_SECOND   = 3'h2,
    CKS_PATH_LOW_INT  = 3'h3,
    CKS_PATH_HIGH_INT = 3'h4
  } cks_path_t;

  // glitch-free switch states, gray along run -> hold -> arm; arm -> run flips both bits
  typedef enum logic [1:0] {
    CKS_ST_RUN  = 2'h0,
    CKS_ST_HOLD = 2'h1,
    CKS_ST_ARM  = 2'h3
  } cks_state_t;

  // ****************************************************************
  // software control fields and reset values
  // ****************************************************************
  localparam logic [2:0] CKS_IFS_LOW_FREQ   = 3'h0;
  localparam logic [2:0] CKS_IFS_RESET      = 3'h3;  // 1 MHz out of the postscaler
  localparam logic [2:0] CKS_IFS_TOP        = 3'h7;  // undivided high-frequency source
  localparam logic [2:0] CKS_IFS_PLL_MIN    = 3'h6;  // 8 MHz and above may feed the multiplier
  localparam int         CKS_POST_WIDTH     = 9;     // 16 MHz / 512 = 31.25 kHz
  localparam int         CKS_INSTRUCTION_CLOCK_OUTPUT_DIV_BIT = 1;     // two-bit counter, divide by four
  localparam int         CKS_SYNC_STAGES    = 2;
  localparam int         CKS_NUM_INPUTS     = 6;

  // input bit positions in the synchroniser vector
  localparam int CKS_IN_PRIMARY = 0;
  localparam int CKS_IN_SECOND  = 1;
  localparam int CKS_IN_HIGH    = 2;
  localparam int CKS_IN_LOW     = 3;
  localparam int CKS_IN_PLL     = 4;
  localparam int CKS_IN_LOCK    = 5;

  typedef struct packed {
    logic [1:0] clock_source_select;
    logic [2:0] internal_freq_select;
    logic       low_freq_source_select;
    logic       primary_osc_run;
    logic       pll_sw_enable;
  } cks_ctrl_t;

  localparam cks_ctrl_t CKS_CTRL_RESET = '{
    clock_source_select:    CKS_SRC_PRIMARY,
    internal_freq_select:   CKS_IFS_RESET,
    low_freq_source_select: 1'b0,
    primary_osc_run:        1'b1,
    pll_sw_enable:          1'b0
  };

  typedef struct packed {
    logic [4:0] mode;
    logic       primary_sw_control_enable;
    logic       pll_config_enable;
  } cks_config_t;

endpackage : cks_pkg

// >>> hdl/cks_postscaler.sv
// high-frequency internal oscillator postscaler
// assumes src_rise is a one-cycle pulse per rising edge of an already synchronised source

`timescale 1ns/10ps

module cks_postscaler
  import cks_pkg::*;
#(
  parameter int WIDTH = CKS_POST_WIDTH
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       src_level,
  input  wire logic       src_rise,
  input  wire logic [2:0] freq_select,
  output logic            post_level
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_post_level;

  // ****************************************************************
  // divide by 2^(7-select) for selects 1 to 7; select 0 gives the 31.25 kHz tap, divide by 512
  // ****************************************************************
  always_comb begin
    next_count = src_rise ? count + {{(WIDTH-1){1'b0}}, 1'b1} : count;
    case (freq_select)
      CKS_IFS_TOP: next_post_level = src_level;
      3'h6:        next_post_level = count[0];
      3'h5:        next_post_level = count[1];
      3'h4:        next_post_level = count[2];
      3'h3:        next_post_level = count[3];
      3'h2:        next_post_level = count[4];
      3'h1:        next_post_level = count[5];
      default:     next_post_level = count[WIDTH-1];
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count      <= '0;
      post_level <= 1'b0;
    end else begin
      count      <= next_count;
      post_level <= next_post_level;
    end
  end

endmodule // cks_postscaler

// >>> hdl/cks_selector.sv
// system clock source selector: source mux, internal oscillator choice, primary shutdown,
// multiplier enable and clock output on the second oscillator pin
// assumes oscillator levels arrive asynchronously and are far slower than core_clk where
// they are passed on; the fuse fields are static and already on core_clk

`timescale 1ns/10ps

module cks_selector
  import cks_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire cks_config_t clock_config_word,
  input  wire logic        ctrl_write,
  input  wire cks_ctrl_t   ctrl_wdata,
  input  wire logic        primary_osc_in,
  input  wire logic        secondary_osc_in,
  input  wire logic        high_freq_internal_osc,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        pll_clk_in,
  input  wire logic        pll_locked_in,
  output cks_ctrl_t        ctrl_rdata,
  output logic             sys_clk,
  output cks_path_t        active_path,
  output logic             switch_busy,
  output logic             primary_osc_enable,
  output logic             pll_enable,
  output logic             second_osc_pin_out,
  output logic             second_osc_pin_oe_n
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [CKS_NUM_INPUTS-1:0] raw_in;
  logic [CKS_NUM_INPUTS-1:0] sync_meta;
  logic [CKS_NUM_INPUTS-1:0] sync_level;
  logic [CKS_NUM_INPUTS-1:0] sync_prev;
  logic [CKS_NUM_INPUTS-1:0] sync_rise;

  assign raw_in = {pll_locked_in, pll_clk_in, low_freq_internal_osc,
                   high_freq_internal_osc, secondary_osc_in, primary_osc_in};

  // stage one feeds only stage two; edges are taken from stage two onward
  genvar gi;
  generate
    for (gi = 0; gi < CKS_NUM_INPUTS; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          sync_meta[gi]  <= 1'b0;
          sync_level[gi] <= 1'b0;
          sync_prev[gi]  <= 1'b0;
        end else begin
          sync_meta[gi]  <= raw_in[gi];
          sync_level[gi] <= sync_meta[gi];
          sync_prev[gi]  <= sync_level[gi];
        end
      end
      assign sync_rise[gi] = sync_level[gi] & ~sync_prev[gi];
    end
  endgenerate

  // ****************************************************************
  // software control fields
  // ****************************************************************
  cks_ctrl_t ctrl;
  cks_ctrl_t next_ctrl;

  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_write) begin
      next_ctrl = ctrl_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl <= CKS_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ****************************************************************
  // high-frequency postscaler
  // ****************************************************************
  logic high_post_level;

  cks_postscaler #(
    .WIDTH (CKS_POST_WIDTH)
  ) u_postscaler (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .src_level   (sync_level[CKS_IN_HIGH]),
    .src_rise    (sync_rise[CKS_IN_HIGH]),
    .freq_select (ctrl.internal_freq_select),
    .post_level  (high_post_level)
  );

  // ****************************************************************
  // path selection
  // ****************************************************************
  logic      mode_internal;
  logic      mode_instruction_clock_output;
  logic      low_int_pick;
  logic      pll_allowed;
  logic      pll_run;
  cks_path_t want_path;

  always_comb begin
    mode_internal = 1'b0;
    mode_instruction_clock_output   = 1'b0;
    case (clock_config_word.mode[3:0])
      CKS_MODE_INTERNAL:                mode_internal = 1'b1;
      CKS_MODE_INTERNAL_INSTRUCTION_CLOCK_OUTPUT: begin
        mode_internal = 1'b1;
        mode_instruction_clock_output   = 1'b1;
      end
      CKS_MODE_EXTERNAL_RC_INSTRUCTION_CLOCK_OUTPUT,
      CKS_MODE_EXT_CLOCK_LOW_INSTRUCTION_CLOCK_OUTPUT,
      CKS_MODE_EXT_CLOCK_MEDIUM_INSTRUCTION_CLOCK_OUTPUT,
      CKS_MODE_EXT_CLOCK_HIGH_INSTRUCTION_CLOCK_OUTPUT:   mode_instruction_clock_output = 1'b1;
      default:                          mode_instruction_clock_output = 1'b0;
    endcase
    // the low source only for select 000 with the low source bit clear
    low_int_pick = (ctrl.internal_freq_select == CKS_IFS_LOW_FREQ) &&
                   !ctrl.low_freq_source_select;
    // in internal modes software may only enable the multiplier at select 6 or above; other modes always allow it
    pll_allowed = mode_internal ? (ctrl.internal_freq_select >= CKS_IFS_PLL_MIN)
                                : !low_int_pick || 1'b1;
    pll_run = clock_config_word.pll_config_enable ||
              (ctrl.pll_sw_enable && pll_allowed);
    if (ctrl.clock_source_select[CKS_SRC_INT_BIT] ||
        (ctrl.clock_source_select == CKS_SRC_PRIMARY && mode_internal)) begin
      if (pll_run && !low_int_pick && sync_level[CKS_IN_LOCK] &&
          !ctrl.clock_source_select[CKS_SRC_INT_BIT]) begin
        want_path = CKS_PATH_PLL;
      end else begin
        want_path = low_int_pick ? CKS_PATH_LOW_INT : CKS_PATH_HIGH_INT;
      end
    end else if (ctrl.clock_source_select == CKS_SRC_SECONDARY) begin
      want_path = CKS_PATH_SECOND;
    end else if (pll_run && sync_level[CKS_IN_LOCK]) begin
      want_path = CKS_PATH_PLL;
    end else begin
      want_path = CKS_PATH_PRIMARY;
    end
  end

  function automatic logic path_level(input cks_path_t p,
                                      input logic [CKS_NUM_INPUTS-1:0] lvl,
                                      input logic post);
    case (p)
      CKS_PATH_PRIMARY: path_level = lvl[CKS_IN_PRIMARY];
      CKS_PATH_PLL:     path_level = lvl[CKS_IN_PLL];
      CKS_PATH_SECOND:  path_level = lvl[CKS_IN_SECOND];
      CKS_PATH_LOW_INT: path_level = lvl[CKS_IN_LOW];
      default:          path_level = post;
    endcase
  endfunction

  // ****************************************************************
  // glitch-free switch
  // ****************************************************************
  cks_state_t state;
  cks_state_t next_state;
  cks_path_t  next_active_path;
  logic       next_sys_clk;
  logic       cur_level;
  logic       new_level;

  always_comb begin
    cur_level        = path_level(active_path, sync_level, high_post_level);
    new_level        = path_level(want_path, sync_level, high_post_level);
    next_state       = state;
    next_active_path = active_path;
    next_sys_clk     = cur_level;
    case (state)
      CKS_ST_RUN: begin
        if (want_path != active_path) begin
          next_state = CKS_ST_HOLD;
        end
      end
      CKS_ST_HOLD: begin
        // finish the current high phase, then park low
        if (!sys_clk) begin
          next_sys_clk = 1'b0;
          next_state   = CKS_ST_ARM;
        end
      end
      CKS_ST_ARM: begin
        next_sys_clk = 1'b0;
        // only a low level of the new source arms it, so its first high is whole
        if (!new_level) begin
          next_active_path = want_path;
          next_state       = CKS_ST_RUN;
        end
      end
      default: begin
        next_sys_clk = 1'b0;
        next_state   = CKS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state       <= CKS_ST_RUN;
      active_path <= CKS_PATH_PRIMARY;
      sys_clk     <= 1'b0;
    end else begin
      state       <= next_state;
      active_path <= next_active_path;
      sys_clk     <= next_sys_clk;
    end
  end

  // ****************************************************************
  // primary oscillator run control, multiplier enable, status
  // ****************************************************************
  logic primary_in_use;
  logic next_primary_osc_enable;
  logic next_pll_enable;
  logic next_switch_busy;

  always_comb begin
    primary_in_use = (active_path == CKS_PATH_PRIMARY) ||
                     (active_path == CKS_PATH_PLL && !mode_internal) ||
                     (want_path == CKS_PATH_PRIMARY);
    next_primary_osc_enable = !clock_config_word.primary_sw_control_enable ||
                              ctrl.primary_osc_run ||
                              primary_in_use;
    next_pll_enable  = pll_run;
    next_switch_busy = (next_state != CKS_ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primary_osc_enable <= 1'b1;
      pll_enable         <= 1'b0;
      switch_busy        <= 1'b0;
      ctrl_rdata         <= CKS_CTRL_RESET;
    end else begin
      primary_osc_enable <= next_primary_osc_enable;
      pll_enable         <= next_pll_enable;
      switch_busy        <= next_switch_busy;
      ctrl_rdata         <= next_ctrl;
    end
  end

  // ****************************************************************
  // clock output on the second oscillator pin
  // ****************************************************************
  logic [CKS_INSTRUCTION_CLOCK_OUTPUT_DIV_BIT:0] instruction_clock_output_count;
  logic [CKS_INSTRUCTION_CLOCK_OUTPUT_DIV_BIT:0] next_instruction_clock_output_count;
  logic                        sys_clk_prev;
  logic                        next_pin_out;
  logic                        next_pin_oe_n;

  always_comb begin
    next_instruction_clock_output_count = instruction_clock_output_count;
    if (sys_clk && !sys_clk_prev) begin
      next_instruction_clock_output_count = instruction_clock_output_count + {{CKS_INSTRUCTION_CLOCK_OUTPUT_DIV_BIT{1'b0}}, 1'b1};
    end
    next_pin_out  = instruction_clock_output_count[CKS_INSTRUCTION_CLOCK_OUTPUT_DIV_BIT];
    next_pin_oe_n = !mode_instruction_clock_output;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      instruction_clock_output_count        <= '0;
      sys_clk_prev        <= 1'b0;
      second_osc_pin_out  <= 1'b0;
      second_osc_pin_oe_n <= 1'b1;
    end else begin
      instruction_clock_output_count        <= next_instruction_clock_output_count;
      sys_clk_prev        <= sys_clk;
      second_osc_pin_out  <= next_pin_out;
      second_osc_pin_oe_n <= next_pin_oe_n;
    end
  end

endmodule // cks_selector

// >>> verification/cks_selector_sva.sv
// checker for the clock source selector: timing relations seen at the ports
// assumes a single core_clk domain and the synchronous active-low reset
`timescale 1ns/10ps

module cks_selector_sva
  import cks_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire cks_config_t clock_config_word,
  input wire logic        ctrl_write,
  input wire cks_ctrl_t   ctrl_wdata,
  input wire logic        primary_osc_in,
  input wire logic        secondary_osc_in,
  input wire logic        high_freq_internal_osc,
  input wire logic        low_freq_internal_osc,
  input wire logic        pll_clk_in,
  input wire logic        pll_locked_in,
  input wire cks_ctrl_t   ctrl_rdata,
  input wire logic        sys_clk,
  input wire cks_path_t   active_path,
  input wire logic        switch_busy,
  input wire logic        primary_osc_enable,
  input wire logic        pll_enable,
  input wire logic        second_osc_pin_out,
  input wire logic        second_osc_pin_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wire logic [3:0] md = clock_config_word.mode[3:0];
  wire logic       sw_fuse = clock_config_word.primary_sw_control_enable;

  // ****************************************
  // settled selections
  // ****************************************
  sequence s_second_held;
    (ctrl_rdata.clock_source_select == CKS_SRC_SECONDARY && !switch_busy) [*3];
  endsequence
  sequence s_low_held;
    (ctrl_rdata.clock_source_select[1] && !ctrl_rdata.low_freq_source_select &&
     ctrl_rdata.internal_freq_select == CKS_IFS_LOW_FREQ && !switch_busy) [*3];
  endsequence
  // primary neither selected nor feeding the multiplier, software asks it off
  sequence s_off_held;
    (sw_fuse && !ctrl_rdata.primary_osc_run && !pll_enable && !switch_busy &&
     ctrl_rdata.clock_source_select != CKS_SRC_PRIMARY) [*3];
  endsequence

  a_reset_value: assert property ($rose(rst_n) |-> ctrl_rdata == CKS_CTRL_RESET &&
    active_path == CKS_PATH_PRIMARY) else $error("readback not at reset value");
  a_write_back: assert property (ctrl_write |=> ctrl_rdata == $past(ctrl_wdata))
    else $error("written fields not read back");
  a_fields_hold: assert property (!ctrl_write |=> $stable(ctrl_rdata))
    else $error("fields changed without a write");
  a_path_second: assert property (s_second_held |-> active_path == CKS_PATH_SECOND)
    else $error("secondary not selected");
  a_path_low: assert property (s_low_held |-> active_path == CKS_PATH_LOW_INT)
    else $error("low-frequency internal not selected");
  a_fuse_keeps_on: assert property (!sw_fuse && !$past(sw_fuse) |-> primary_osc_enable)
    else $error("primary stopped without software control");
  a_in_use_on: assert property (active_path == CKS_PATH_PRIMARY &&
    $past(active_path) == CKS_PATH_PRIMARY |-> primary_osc_enable)
    else $error("primary stopped while it is the system clock");
  a_run_bit_off: assert property (s_off_held |-> !primary_osc_enable)
    else $error("primary kept running after shutdown");
  a_glitch_free: assert property ($changed(active_path) |-> !sys_clk && !$past(sys_clk))
    else $error("source changed while the clock was high");
  // a slow postscaled source may hold both the old high phase and the new high phase
  // for about a thousand cycles each, so the bound is kept in a counter
  localparam int SWITCH_CAP = 2100;
  int busy_run;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !switch_busy) begin
      busy_run <= 0;
    end else begin
      busy_run <= busy_run + 1;
    end
  end
  a_switch_bound: assert property (busy_run <= SWITCH_CAP)
    else $error("clock switch did not finish");
  a_pll_fuse: assert property (clock_config_word.pll_config_enable && $past(rst_n) &&
    $past(clock_config_word.pll_config_enable) |-> pll_enable)
    else $error("multiplier off while enabled by fuse");
  a_instruction_clock_output_oe: assert property ($stable(md) && $past(rst_n) |->
    second_osc_pin_oe_n == !(md inside {4'h4, 4'h6, 4'h8, 4'hA, 4'hC}))
    else $error("clock output enable does not match the mode");
endmodule // cks_selector_sva

bind cks_selector cks_selector_sva i_cks_selector_sva (
  .core_clk(core_clk), .rst_n(rst_n), .clock_config_word(clock_config_word),
  .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata), .primary_osc_in(primary_osc_in),
  .secondary_osc_in(secondary_osc_in), .high_freq_internal_osc(high_freq_internal_osc),
  .low_freq_internal_osc(low_freq_internal_osc), .pll_clk_in(pll_clk_in),
  .pll_locked_in(pll_locked_in), .ctrl_rdata(ctrl_rdata), .sys_clk(sys_clk),
  .active_path(active_path), .switch_busy(switch_busy),
  .primary_osc_enable(primary_osc_enable), .pll_enable(pll_enable),
  .second_osc_pin_out(second_osc_pin_out), .second_osc_pin_oe_n(second_osc_pin_oe_n));

// >>> verification/testbench.sv
// self-checking bench for the clock source selector
// assumes the oscillators are modelled as slow levels derived from core_clk counters
`timescale 1ns/10ps

module testbench
  import cks_pkg::*;
;
  logic        core_clk, rst_n, ctrl_write, pll_locked_in;
  cks_config_t cfg;
  cks_ctrl_t   wdata, rdata;
  logic        prim, sec, hfo, lfo, pllc;
  logic        sys_clk, busy, prim_en, pll_en, pin_out, pin_oe_n;
  cks_path_t   path;
  logic [7:0]  cnt;
  int          fail_count, total_checks, sys_rise, pin_tgl, prim_rise;
  logic        sys_q, pin_q, prim_q;

  cks_selector i_cks_selector (
    .core_clk(core_clk), .rst_n(rst_n), .clock_config_word(cfg), .ctrl_write(ctrl_write),
    .ctrl_wdata(wdata), .primary_osc_in(prim), .secondary_osc_in(sec),
    .high_freq_internal_osc(hfo), .low_freq_internal_osc(lfo), .pll_clk_in(pllc),
    .pll_locked_in(pll_locked_in), .ctrl_rdata(rdata), .sys_clk(sys_clk),
    .active_path(path), .switch_busy(busy), .primary_osc_enable(prim_en),
    .pll_enable(pll_en), .second_osc_pin_out(pin_out), .second_osc_pin_oe_n(pin_oe_n));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************
  // oscillators at slow power-of-two rates from one counter, edge counters
  // ****************************************
  always @(posedge core_clk) begin
    cnt <= cnt + 8'h01;
    prim <= cnt[2];
    sec <= cnt[4];
    hfo <= cnt[1];
    lfo <= cnt[5];
    pllc <= ~cnt[1];
    sys_q <= sys_clk;
    pin_q <= pin_out;
    prim_q <= prim;
    if (sys_clk === 1'b1 && sys_q === 1'b0) sys_rise++;
    if (pin_out !== pin_q) pin_tgl++;
    if (prim === 1'b1 && prim_q === 1'b0) prim_rise++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic cks_path_t exp_path(cks_ctrl_t c);
    if (c.clock_source_select[1])
      return (c.internal_freq_select == 3'h0 && !c.low_freq_source_select) ?
             CKS_PATH_LOW_INT : CKS_PATH_HIGH_INT;
    if (c.clock_source_select[0]) return CKS_PATH_SECOND;
    return (cfg.pll_config_enable && pll_locked_in) ? CKS_PATH_PLL : CKS_PATH_PRIMARY;
  endfunction

  // write all fields, then wait for any switch to settle
  task automatic apply(input cks_ctrl_t c);
    int n;
    @(posedge core_clk);
    ctrl_write <= 1'b1;
    wdata <= c;
    @(posedge core_clk);
    ctrl_write <= 1'b0;
    #1 check(rdata, c);
    repeat (3) @(posedge core_clk);
    n = 0;
    while (busy !== 1'b0 && n < 2200) begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    #1 check(path, exp_path(c));
    check(busy, 1'b0);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 check(rdata, 8'h1A);
    check(path, CKS_PATH_PRIMARY);
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    summarize();
  end

  initial begin
    cks_ctrl_t c;
    void'($urandom(32'h41acce35));
    {rst_n, ctrl_write, pll_locked_in, cnt} = 11'h000;
    {prim, sec, hfo, lfo, pllc, sys_q, pin_q, prim_q} = 8'h00;
    wdata = CKS_CTRL_RESET;
    cfg = '{mode: 5'h02, primary_sw_control_enable: 1'b0, pll_config_enable: 1'b0};
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 check(rdata, 8'h1A);
    for (int i = 0; i < 12; i++) begin
      c = cks_ctrl_t'(8'($urandom) & 8'hFE);
      if (i == 0) c = 8'hC2;
      if (i == 1) c = 8'hC6;
      apply(c);
    end
    apply(8'h42);
    check(prim_en, 1'b1);
    @(posedge core_clk) cfg.primary_sw_control_enable <= 1'b1;
    apply(8'h18);
    check(prim_en, 1'b1);
    apply(8'h58);
    check(prim_en, 1'b0);
    apply(8'h5A);
    check(prim_en, 1'b1);
    apply(8'h98);
    check(prim_en, 1'b0);
    // the multiplied primary stays a mid-rate source, inside the multiplier's input range
    @(posedge core_clk) {cfg.pll_config_enable, pll_locked_in} <= 2'h3;
    apply(8'h1A);
    check(pll_en, 1'b1);
    @(posedge core_clk) {cfg.pll_config_enable, pll_locked_in} <= 2'h0;
    apply(8'h1A);
    for (int m = 0; m < 16; m++) begin
      @(posedge core_clk) cfg.mode <= 5'(m);
      repeat (3) @(posedge core_clk);
      #1 check(pin_oe_n, !(m inside {4, 6, 8, 10, 12}));
    end
    @(posedge core_clk) cfg.mode <= 5'h08;
    repeat (20) @(posedge core_clk);
    sys_rise = 0;
    pin_tgl = 0;
    prim_rise = 0;
    repeat (400) @(posedge core_clk);
    check((sys_rise - prim_rise) inside {-1, 0, 1}, 1'b1);
    check((sys_rise - 2 * pin_tgl) inside {-2, -1, 0, 1, 2}, 1'b1);
    apply(8'h5A);
    do_reset();
    summarize();
  end
endmodule // testbench
